//--- core/acfl_core.sv
`timescale 1ns/1ps
module acfl_core
    import acfl_pkg::*;
(
    input wire logic clk_sys, // core clock
    input wire logic arst_n, // async reset, active low
    input wire logic op_valid, // execute op this cycle
    input wire acfl_pkg::acfl_op_e op_code, // operation
    input wire acfl_pkg::acfl_src_e op_dst, // target accumulator or memory
    input wire acfl_pkg::acfl_src_e op_src, // right operand source
    input wire logic [15:0] mem_data, // memory operand, 16 bits for double ops
    output logic [7:0] accumulator_a, // accumulator a
    output logic [7:0] accumulator_b, // accumulator b
    output logic [7:0] condition_flags, // flag register
    output logic [7:0] mem_wdata, // memory result
    output logic mem_we // memory write strobe
);
    import acfl_pkg::*;

    // ----------------------------------------
    // state
    // ----------------------------------------
    logic [7:0] acc_a_q, acc_a_d;
    logic [7:0] acc_b_q, acc_b_d;
    logic [5:0] flags_q, flags_d;
    logic [7:0] mem_wdata_q, mem_wdata_d;
    logic mem_we_q, mem_we_d;

    logic [7:0] left8, right8, res8;
    logic [15:0] add_a, add_b, product;
    logic add_cin, add_sub, add_wide;
    logic wr_res, nz_upd;
    logic bcd_lo_fix, bcd_hi_fix;

    acfl_flag_if add_res ();

    // ----------------------------------------
    // datapath units
    // ----------------------------------------
    acfl_adder u_adder (
        .opa(add_a),
        .opb(add_b),
        .carry_in(add_cin),
        .subtract(add_sub),
        .wide(add_wide),
        .res(add_res)
    );

    acfl_multiplier u_mult (
        .fac_a(acc_a_q),
        .fac_b(acc_b_q),
        .product(product)
    );

    // operand select
    always_comb begin
        case (op_dst)
            SRC_ACC_B: left8 = acc_b_q;
            SRC_MEM: left8 = mem_data[7:0];
            default: left8 = acc_a_q;
        endcase
        case (op_src)
            SRC_ACC_A: right8 = acc_a_q;
            SRC_ACC_B: right8 = acc_b_q;
            default: right8 = mem_data[7:0];
        endcase
        add_wide = (op_code == OP_DOUBLE_ADD) || (op_code == OP_DOUBLE_SUBTRACT);
        add_sub = (op_code == OP_SUBTRACT) || (op_code == OP_SUBTRACT_BORROW)
                  || (op_code == OP_DOUBLE_SUBTRACT) || (op_code == OP_COMPARE);
        add_cin = ((op_code == OP_ADD_CARRY) || (op_code == OP_SUBTRACT_BORROW)) && flags_q[FLG_C];
        add_a = add_wide ? {acc_a_q, acc_b_q} : {8'h00, left8};
        add_b = add_wide ? mem_data : {8'h00, right8};
        bcd_lo_fix = flags_q[FLG_H] || (acc_a_q[3:0] > BCD_NINE);
        bcd_hi_fix = flags_q[FLG_C] || (acc_a_q[7:4] > BCD_NINE)
                     || ((acc_a_q[7:4] == BCD_NINE) && (acc_a_q[3:0] > BCD_NINE));
    end

    // ----------------------------------------
    // next-state for accumulators and flags
    // ----------------------------------------
    always_comb begin
        acc_a_d = acc_a_q;
        acc_b_d = acc_b_q;
        flags_d = flags_q;
        mem_wdata_d = mem_wdata_q;
        mem_we_d = 1'b0;
        res8 = left8;
        wr_res = 1'b0;
        nz_upd = 1'b0;
        if (op_valid) begin
            case (op_code)
                OP_CLEAR_CARRY: flags_d[FLG_C] = 1'b0;
                OP_SET_CARRY: flags_d[FLG_C] = 1'b1;
                OP_CLEAR_OVERFLOW: flags_d[FLG_V] = 1'b0;
                OP_SET_OVERFLOW: flags_d[FLG_V] = 1'b1;
                OP_CLEAR_INT_MASK: flags_d[FLG_I] = 1'b0;
                OP_SET_INT_MASK: flags_d[FLG_I] = 1'b1;
                OP_ACC_TO_FLAGS: flags_d = acc_a_q[5:0];
                OP_FLAGS_TO_ACC: acc_a_d = FLAGS_FIXED | {2'b00, flags_q};
                OP_ADD, OP_ADD_CARRY: begin
                    res8 = add_res.sum[7:0];
                    wr_res = 1'b1;
                    nz_upd = 1'b1;
                    flags_d[FLG_H] = add_res.half_carry;
                    flags_d[FLG_V] = add_res.overflow;
                    flags_d[FLG_C] = add_res.carry;
                end
                OP_SUBTRACT, OP_SUBTRACT_BORROW, OP_COMPARE: begin
                    res8 = add_res.sum[7:0];
                    wr_res = (op_code != OP_COMPARE);
                    nz_upd = 1'b1;
                    flags_d[FLG_V] = add_res.overflow;
                    flags_d[FLG_C] = add_res.carry;
                end
                OP_DOUBLE_ADD, OP_DOUBLE_SUBTRACT: begin
                    acc_a_d = add_res.sum[15:8];
                    acc_b_d = add_res.sum[7:0];
                    flags_d[FLG_N] = add_res.sum[15];
                    flags_d[FLG_Z] = (add_res.sum == 16'h0000);
                    flags_d[FLG_V] = add_res.overflow;
                    flags_d[FLG_C] = add_res.carry;
                end
                OP_DECIMAL_ADJUST: begin
                    acc_a_d = acc_a_q + (bcd_lo_fix ? BCD_FIX_LO : 8'h00)
                              + (bcd_hi_fix ? BCD_FIX_HI : 8'h00);
                    flags_d[FLG_N] = acc_a_d[7];
                    flags_d[FLG_Z] = (acc_a_d == 8'h00);
                    flags_d[FLG_V] = 1'b0;
                    flags_d[FLG_C] = flags_q[FLG_C] | bcd_hi_fix;
                end
                OP_MULTIPLY: begin
                    acc_a_d = product[15:8];
                    acc_b_d = product[7:0];
                    flags_d[FLG_C] = product[7];
                end
                OP_AND, OP_XOR, OP_OR, OP_BIT_TEST: begin
                    case (op_code)
                        OP_XOR: res8 = left8 ^ right8;
                        OP_OR: res8 = left8 | right8;
                        default: res8 = left8 & right8;
                    endcase
                    wr_res = (op_code != OP_BIT_TEST);
                    nz_upd = 1'b1;
                    flags_d[FLG_V] = 1'b0;
                end
                OP_ONES_COMPLEMENT: begin
                    res8 = ~left8;
                    wr_res = 1'b1;
                    nz_upd = 1'b1;
                    flags_d[FLG_V] = 1'b0;
                    flags_d[FLG_C] = 1'b1;
                end
                OP_TEST_ZERO: begin
                    res8 = left8;
                    nz_upd = 1'b1;
                    flags_d[FLG_V] = 1'b0;
                    flags_d[FLG_C] = 1'b0;
                end
                OP_LOAD: begin
                    res8 = right8;
                    wr_res = 1'b1;
                    nz_upd = 1'b1;
                    flags_d[FLG_V] = 1'b0;
                end
                OP_CLEAR: begin
                    res8 = 8'h00;
                    wr_res = 1'b1;
                    nz_upd = 1'b1;
                    flags_d[FLG_V] = 1'b0;
                    flags_d[FLG_C] = 1'b0;
                end
                default: ;
            endcase
            // common negative/zero update
            if (nz_upd) begin
                flags_d[FLG_N] = res8[7];
                flags_d[FLG_Z] = (res8 == 8'h00);
            end
            // write back only for result-producing ops
            if (wr_res) begin
                case (op_dst)
                    SRC_ACC_B: acc_b_d = res8;
                    SRC_MEM: begin
                        mem_wdata_d = res8;
                        mem_we_d = 1'b1;
                    end
                    default: acc_a_d = res8;
                endcase
            end
        end
    end

    // register stage
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            acc_a_q <= ACC_RESET;
            acc_b_q <= ACC_RESET;
            flags_q <= FLAGS_RESET;
            mem_wdata_q <= ACC_RESET;
            mem_we_q <= 1'b0;
        end else begin
            acc_a_q <= acc_a_d;
            acc_b_q <= acc_b_d;
            flags_q <= flags_d;
            mem_wdata_q <= mem_wdata_d;
            mem_we_q <= mem_we_d;
        end
    end

    assign accumulator_a = acc_a_q;
    assign accumulator_b = acc_b_q;
    assign condition_flags = FLAGS_FIXED | {2'b00, flags_q};
    assign mem_wdata = mem_wdata_q;
    assign mem_we = mem_we_q;

    // ----------------------------------------
    // checks
    // ----------------------------------------
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!arst_n);

    a_fixed_bits_one: assert property (condition_flags[7:6] == 2'b11)
        else $error("fixed flag bits not one");
    a_clear_carry_only: assert property (op_valid && op_code == OP_CLEAR_CARRY |=>
        !condition_flags[0] && condition_flags[5:1] == $past(condition_flags[5:1]))
        else $error("clear carry wrong");
    a_set_mask_only: assert property (op_valid && op_code == OP_SET_INT_MASK |=>
        condition_flags[4] && condition_flags[3:0] == $past(condition_flags[3:0])
        && condition_flags[5] == $past(condition_flags[5]))
        else $error("set mask wrong");
    a_acc_to_flags: assert property (op_valid && op_code == OP_ACC_TO_FLAGS |=>
        condition_flags[5:0] == $past(accumulator_a[5:0]))
        else $error("acc to flags wrong");
    a_flags_to_acc: assert property (op_valid && op_code == OP_FLAGS_TO_ACC |=>
        accumulator_a == $past(condition_flags) && condition_flags == $past(condition_flags))
        else $error("flags to acc wrong");
    a_double_keeps_half: assert property (op_valid && op_code == OP_DOUBLE_ADD |=>
        condition_flags[5] == $past(condition_flags[5])
        && condition_flags[2] == ({accumulator_a, accumulator_b} == 16'h0000))
        else $error("double add flags wrong");
    a_sub_keeps_half: assert property (op_valid && add_sub |=>
        condition_flags[5:4] == $past(condition_flags[5:4]))
        else $error("subtract touched h or i");
    a_multiply_product: assert property (op_valid && op_code == OP_MULTIPLY |=>
        {accumulator_a, accumulator_b} == $past(accumulator_a) * $past(accumulator_b)
        && condition_flags[5:1] == $past(condition_flags[5:1]))
        else $error("multiply wrong");
    // logic group issue (and, xor, or), used only by the logic flag check
    sequence s_logic_issue;
        op_valid && (op_code == OP_AND || op_code == OP_XOR || op_code == OP_OR);
    endsequence
    a_logic_keeps_carry: assert property (s_logic_issue |=> !condition_flags[1]
        && condition_flags[5] == $past(condition_flags[5]) && condition_flags[0] == $past(condition_flags[0]))
        else $error("logic op flags wrong");
    a_complement_carry: assert property (op_valid && op_code == OP_ONES_COMPLEMENT |=>
        condition_flags[0] && !condition_flags[1])
        else $error("complement flags wrong");
    a_test_no_write: assert property (op_valid && (op_code == OP_COMPARE || op_code == OP_BIT_TEST
        || op_code == OP_TEST_ZERO) |=> !mem_we && accumulator_a == $past(accumulator_a))
        else $error("test op wrote back");
    a_bit_test_carry: assert property (op_valid && op_code == OP_BIT_TEST |=>
        !condition_flags[1] && condition_flags[0] == $past(condition_flags[0]))
        else $error("bit test flags wrong");
    a_test_zero_vc: assert property (op_valid && op_code == OP_TEST_ZERO |=>
        condition_flags[1:0] == 2'b00)
        else $error("test zero flags wrong");
    a_load_keeps_carry: assert property (op_valid && op_code == OP_LOAD |=>
        condition_flags[0] == $past(condition_flags[0]))
        else $error("load changed carry");
    // carry set, then a load in the next cycle, as in a multi-byte loop
    sequence s_carry_then_load;
        op_valid && op_code == OP_SET_CARRY ##1 op_valid && op_code == OP_LOAD;
    endsequence
    a_loop_carry_kept: assert property (s_carry_then_load |=> condition_flags[0])
        else $error("load in loop lost carry");
    a_load_sets_nz: assert property (op_valid && op_code == OP_LOAD && op_dst == SRC_ACC_A |=>
        condition_flags[3] == accumulator_a[7] && condition_flags[2] == (accumulator_a == 8'h00))
        else $error("load n or z wrong");
    a_clear_a_carry: assert property (op_valid && op_code == OP_CLEAR |=>
        condition_flags[2] && !condition_flags[0])
        else $error("clear flags wrong");
    a_bcd_keeps_carry: assert property (op_valid && op_code == OP_DECIMAL_ADJUST
        && condition_flags[0] |=> condition_flags[0])
        else $error("decimal adjust cleared carry");
endmodule

//--- core/acfl_pkg.sv
package acfl_pkg;
    // flag bit positions
    localparam int FLG_H = 5;
    localparam int FLG_I = 4;
    localparam int FLG_N = 3;
    localparam int FLG_Z = 2;
    localparam int FLG_V = 1;
    localparam int FLG_C = 0;
    // bits 7:6 fixed high
    localparam logic [7:0] FLAGS_FIXED = 8'hC0;
    localparam logic [5:0] FLAGS_RESET = 6'h10;
    localparam logic [7:0] ACC_RESET = 8'h00;
    localparam logic [3:0] BCD_NINE = 4'h9;
    localparam logic [7:0] BCD_FIX_LO = 8'h06;
    localparam logic [7:0] BCD_FIX_HI = 8'h60;

    typedef enum logic [4:0] {
        OP_NOP              = 5'b00000,
        OP_CLEAR_CARRY      = 5'b00001,
        OP_SET_CARRY        = 5'b00010,
        OP_CLEAR_OVERFLOW   = 5'b00011,
        OP_SET_OVERFLOW     = 5'b00100,
        OP_CLEAR_INT_MASK   = 5'b00101,
        OP_SET_INT_MASK     = 5'b00110,
        OP_ACC_TO_FLAGS     = 5'b00111,
        OP_FLAGS_TO_ACC     = 5'b01000,
        OP_ADD              = 5'b01001,
        OP_ADD_CARRY        = 5'b01010,
        OP_DOUBLE_ADD       = 5'b01011,
        OP_SUBTRACT         = 5'b01100,
        OP_SUBTRACT_BORROW  = 5'b01101,
        OP_DOUBLE_SUBTRACT  = 5'b01110,
        OP_DECIMAL_ADJUST   = 5'b01111,
        OP_MULTIPLY         = 5'b10000,
        OP_AND              = 5'b10001,
        OP_XOR              = 5'b10010,
        OP_OR               = 5'b10011,
        OP_ONES_COMPLEMENT  = 5'b10100,
        OP_BIT_TEST         = 5'b10101,
        OP_COMPARE          = 5'b10110,
        OP_TEST_ZERO        = 5'b10111,
        OP_LOAD             = 5'b11000,
        OP_CLEAR            = 5'b11001
    } acfl_op_e;

    // operand sources
    typedef enum logic [1:0] {
        SRC_MEM = 2'b00,
        SRC_ACC_A = 2'b01,
        SRC_ACC_B = 2'b10
    } acfl_src_e;
endpackage

//--- core/acfl_flag_if.sv
`timescale 1ns/1ps
// flag results from the adder to the core
interface acfl_flag_if;
    logic [15:0] sum;
    logic half_carry;
    logic carry;
    logic overflow;
    modport adder (output sum, half_carry, carry, overflow);
    modport core (input sum, half_carry, carry, overflow);
endinterface

//--- core/acfl_adder.sv
`timescale 1ns/1ps
// ----------------------------------------
// 8/16-bit add or subtract with flags
// ----------------------------------------
module acfl_adder (
    input wire logic [15:0] opa, // left operand
    input wire logic [15:0] opb, // right operand
    input wire logic carry_in, // carry or borrow in
    input wire logic subtract, // subtract when high
    input wire logic wide, // 16-bit when high
    acfl_flag_if.adder res // result and flags
);
    logic [16:0] full;
    logic [4:0] low_nib;
    logic [15:0] opb_x;
    logic cin_x;

    // subtract as add of inverse, carry flag becomes borrow
    always_comb begin
        opb_x = subtract ? ~opb : opb;
        cin_x = subtract ? ~carry_in : carry_in;
        full = {1'b0, opa} + {1'b0, opb_x} + {16'h0000, cin_x};
        low_nib = {1'b0, opa[3:0]} + {1'b0, opb_x[3:0]} + {4'h0, cin_x};
        res.sum = full[15:0];
        res.half_carry = low_nib[4];
        if (wide) begin
            res.carry = full[16] ^ subtract;
            res.overflow = (opa[15] == opb_x[15]) && (full[15] != opa[15]);
        end else begin
            res.carry = (opa[8] ^ opb_x[8] ^ full[8]) ^ subtract;
            res.overflow = (opa[7] == opb_x[7]) && (full[7] != opa[7]);
        end
    end
endmodule

//--- core/acfl_multiplier.sv
`timescale 1ns/1ps
// ----------------------------------------
// unsigned 8x8 multiply
// ----------------------------------------
module acfl_multiplier (
    input wire logic [7:0] fac_a, // first factor
    input wire logic [7:0] fac_b, // second factor
    output logic [15:0] product // unsigned product
);
    // product of two accumulators
    always_comb begin
        product = 16'(fac_a) * 16'(fac_b);
    end
endmodule

//--- verif/test_acfl_core.sv
`timescale 1ns/1ps
module test_acfl_core;
    import acfl_pkg::*;
    logic clk_sys;
    logic arst_n;
    logic op_valid;
    acfl_op_e op_code;
    acfl_src_e op_dst;
    acfl_src_e op_src;
    logic [15:0] mem_data;
    logic [7:0] accumulator_a;
    logic [7:0] accumulator_b;
    logic [7:0] condition_flags;
    logic [7:0] mem_wdata;
    logic mem_we;
    int fails;
    int cmp_count;

    acfl_core acfl_core_i (
        .clk_sys(clk_sys),
        .arst_n(arst_n),
        .op_valid(op_valid),
        .op_code(op_code),
        .op_dst(op_dst),
        .op_src(op_src),
        .mem_data(mem_data),
        .accumulator_a(accumulator_a),
        .accumulator_b(accumulator_b),
        .condition_flags(condition_flags),
        .mem_wdata(mem_wdata),
        .mem_we(mem_we)
    );

    // ----------------------------------------
    // clock and shared tasks
    // ----------------------------------------
    // 25 MHz core clock
    initial begin
        clk_sys = 1'b0;
        forever #20 clk_sys = ~clk_sys;
    end

    task automatic chk(input string n, input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            fails++;
            $display("CHECK FAILED %s expected %h seen %h", n, exp, seen);
        end
    endtask

    // accumulator a and flags together
    task automatic ck(input string n, input logic [7:0] ea, input logic [7:0] ef);
        chk({n, " acc_a"}, {8'h00, accumulator_a}, {8'h00, ea});
        chk({n, " flags"}, {8'h00, condition_flags}, {8'h00, ef});
    endtask

    // one op, taken at the next rising edge; returns at the falling edge after
    task automatic op(input acfl_op_e c, input acfl_src_e d, input acfl_src_e s, input logic [15:0] m);
        op_valid = 1'b1;
        op_code = c;
        op_dst = d;
        op_src = s;
        mem_data = m;
        @(negedge clk_sys);
    endtask

    task automatic idle();
        op_valid = 1'b0;
        @(negedge clk_sys);
    endtask

    // load a then copy into flags; a keeps v
    task automatic setf(input logic [7:0] v);
        op(OP_LOAD, SRC_ACC_A, SRC_MEM, {8'h00, v});
        op(OP_ACC_TO_FLAGS, SRC_ACC_A, SRC_MEM, 16'h0000);
        chk("flags fixed bits", {8'h00, condition_flags}, {8'h00, v | 8'hC0});
    endtask

    task automatic ld(input acfl_src_e d, input logic [7:0] v);
        op(OP_LOAD, d, SRC_MEM, {8'h00, v});
    endtask

    task automatic finish_test();
        if (fails == 0 && cmp_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic s_flag_ops();
        acfl_op_e codes [6];
        int bits [6];
        logic [7:0] e;
        codes = '{OP_CLEAR_CARRY, OP_SET_CARRY, OP_CLEAR_OVERFLOW, OP_SET_OVERFLOW,
                  OP_CLEAR_INT_MASK, OP_SET_INT_MASK};
        bits = '{0, 0, 1, 1, 4, 4};
        for (int i = 0; i < 6; i++) begin
            setf((i % 2 == 1) ? 8'h00 : 8'h3F);
            op(codes[i], SRC_ACC_A, SRC_MEM, 16'h0000);
            e = (i % 2 == 1) ? (8'hC0 | (8'h01 << bits[i])) : (8'hFF & ~(8'h01 << bits[i]));
            chk("single flag op", {8'h00, condition_flags}, {8'h00, e});
        end
        setf(8'h2A);
        op(OP_FLAGS_TO_ACC, SRC_ACC_A, SRC_MEM, 16'h0000);
        ck("flags to acc", 8'hEA, 8'hEA);
    endtask

    task automatic s_add();
        setf(8'h00);
        ld(SRC_ACC_B, 8'h00);
        ld(SRC_ACC_A, 8'h0F);
        op(OP_ADD, SRC_ACC_A, SRC_MEM, 16'h0001);
        ck("add half carry", 8'h10, 8'hE0);
        op(OP_ADD, SRC_ACC_A, SRC_MEM, 16'h0070);
        ck("add overflow", 8'h80, 8'hCA);
        op(OP_ADD, SRC_ACC_A, SRC_MEM, 16'h0080);
        ck("add carry out", 8'h00, 8'hC7);
        op(OP_ADD_CARRY, SRC_ACC_A, SRC_ACC_B, 16'h0000);
        ck("add with carry", 8'h01, 8'hC0);
    endtask

    task automatic s_double();
        setf(8'h20);
        ld(SRC_ACC_A, 8'h7F);
        ld(SRC_ACC_B, 8'hFF);
        op(OP_DOUBLE_ADD, SRC_ACC_A, SRC_MEM, 16'h0001);
        ck("double add", 8'h80, 8'hEA);
        chk("double add b", {8'h00, accumulator_b}, 16'h0000);
        op(OP_DOUBLE_SUBTRACT, SRC_ACC_A, SRC_MEM, 16'h0001);
        ck("double sub", 8'h7F, 8'hE2);
        chk("double sub b", {8'h00, accumulator_b}, 16'h00FF);
    endtask

    task automatic s_sub();
        setf(8'h20);
        ld(SRC_ACC_A, 8'h00);
        op(OP_SUBTRACT, SRC_ACC_A, SRC_MEM, 16'h0001);
        ck("sub borrow", 8'hFF, 8'hE9);
        op(OP_SUBTRACT_BORROW, SRC_ACC_A, SRC_MEM, 16'h0000);
        ck("sub with borrow", 8'hFE, 8'hE8);
        op(OP_COMPARE, SRC_ACC_A, SRC_MEM, 16'h00FE);
        ck("compare", 8'hFE, 8'hE4);
        ld(SRC_ACC_B, 8'h05);
        op(OP_COMPARE, SRC_ACC_A, SRC_ACC_B, 16'h0000);
        ck("compare acc", 8'hFE, 8'hE8);
        op(OP_SUBTRACT, SRC_ACC_B, SRC_ACC_A, 16'h0000);
        ck("sub into b", 8'hFE, 8'hE1);
        chk("sub into b value", {8'h00, accumulator_b}, 16'h0007);
    endtask

    task automatic s_daa();
        setf(8'h00);
        ld(SRC_ACC_A, 8'h09);
        op(OP_ADD, SRC_ACC_A, SRC_MEM, 16'h0008);
        op(OP_DECIMAL_ADJUST, SRC_ACC_A, SRC_MEM, 16'h0000);
        ck("bcd low fix", 8'h17, 8'hE0);
        ld(SRC_ACC_A, 8'h99);
        op(OP_ADD, SRC_ACC_A, SRC_MEM, 16'h0001);
        op(OP_DECIMAL_ADJUST, SRC_ACC_A, SRC_MEM, 16'h0000);
        ck("bcd high fix", 8'h00, 8'hC5);
        setf(8'h01);
        ld(SRC_ACC_A, 8'h12);
        op(OP_DECIMAL_ADJUST, SRC_ACC_A, SRC_MEM, 16'h0000);
        ck("bcd carry kept", 8'h72, 8'hC1);
    endtask

    task automatic s_mul();
        setf(8'h00);
        ld(SRC_ACC_A, 8'hFF);
        ld(SRC_ACC_B, 8'hFF);
        op(OP_MULTIPLY, SRC_ACC_A, SRC_MEM, 16'h0000);
        ck("multiply ff", 8'hFE, 8'hC8);
        chk("multiply ff b", {8'h00, accumulator_b}, 16'h0001);
        ld(SRC_ACC_A, 8'h10);
        ld(SRC_ACC_B, 8'h08);
        op(OP_MULTIPLY, SRC_ACC_A, SRC_MEM, 16'h0000);
        ck("multiply bit7", 8'h00, 8'hC1);
        chk("multiply bit7 b", {8'h00, accumulator_b}, 16'h0080);
    endtask

    task automatic s_logic();
        setf(8'h23);
        op(OP_AND, SRC_ACC_A, SRC_MEM, 16'h000F);
        ck("and", 8'h03, 8'hE1);
        op(OP_XOR, SRC_ACC_A, SRC_MEM, 16'h00FF);
        ck("xor", 8'hFC, 8'hE9);
        op(OP_OR, SRC_ACC_A, SRC_MEM, 16'h0003);
        ck("or", 8'hFF, 8'hE9);
        op(OP_AND, SRC_ACC_A, SRC_MEM, 16'h0000);
        ck("and zero", 8'h00, 8'hE5);
        op(OP_ONES_COMPLEMENT, SRC_ACC_A, SRC_MEM, 16'h0000);
        ck("complement a", 8'hFF, 8'hE9);
        op(OP_ONES_COMPLEMENT, SRC_MEM, SRC_MEM, 16'h005A);
        ck("complement mem", 8'hFF, 8'hE9);
        chk("complement mem we", {15'h0000, mem_we}, 16'h0001);
        chk("complement mem data", {8'h00, mem_wdata}, 16'h00A5);
        idle();
        chk("mem we pulse", {15'h0000, mem_we}, 16'h0000);
    endtask

    task automatic s_test();
        setf(8'h01);
        ld(SRC_ACC_A, 8'hF0);
        op(OP_BIT_TEST, SRC_ACC_A, SRC_MEM, 16'h000F);
        ck("bit test", 8'hF0, 8'hC5);
        chk("bit test no write", {15'h0000, mem_we}, 16'h0000);
        op(OP_TEST_ZERO, SRC_MEM, SRC_MEM, 16'h0080);
        ck("test zero mem", 8'hF0, 8'hC8);
        chk("test zero no write", {15'h0000, mem_we}, 16'h0000);
        setf(8'h01);
        ld(SRC_ACC_A, 8'h00);
        ck("load zero", 8'h00, 8'hC5);
        ld(SRC_ACC_A, 8'h55);
        op(OP_CLEAR, SRC_ACC_A, SRC_MEM, 16'h0000);
        ck("clear a", 8'h00, 8'hC4);
        op(OP_NOP, SRC_ACC_A, SRC_MEM, 16'h00FF);
        ck("nop", 8'h00, 8'hC4);
    endtask

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        fails = 0;
        cmp_count = 0;
        arst_n = 1'b0;
        op_valid = 1'b0;
        op_code = OP_NOP;
        op_dst = SRC_ACC_A;
        op_src = SRC_MEM;
        mem_data = 16'h0000;
        repeat (10) @(negedge clk_sys);
        ck("reset", 8'h00, 8'hD0);
        chk("reset b", {8'h00, accumulator_b}, 16'h0000);
        chk("reset we", {15'h0000, mem_we}, 16'h0000);
        arst_n = 1'b1;
        @(negedge clk_sys);
        s_flag_ops();
        s_add();
        s_double();
        s_sub();
        s_daa();
        s_mul();
        s_logic();
        s_test();
        idle();
        finish_test();
    end
endmodule
